// ==== verilog/fswd_pkg.sv ====
// Package for the fieldbus slave output watchdog block
package fswd_pkg;

  // Time base
  localparam int unsigned CLK_SYS_MHZ      = 250;
  localparam int unsigned BASE_PERIOD_NS   = 40;
  localparam int unsigned BASE_CYCLES      =
    (BASE_PERIOD_NS * CLK_SYS_MHZ) / 1000;
  localparam logic [3:0]  BASE_CNT_LAST    = 4'(BASE_CYCLES - 1);
  localparam logic [16:0] TICK_EXTRA_BASES = 17'h00002;

  // Values after reset
  localparam logic [15:0] RST_MULT       = 16'h09c2;
  localparam logic [15:0] RST_SYNC_TICKS = 16'h03e8;
  localparam logic [15:0] RST_APP_TICKS  = 16'h03e8;
  localparam logic [15:0] RST_OUT_VALUE  = 16'h0000;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_MULT       = 8'h04;
  localparam logic [7:0] OFS_SYNC_TICKS = 8'h08;
  localparam logic [7:0] OFS_APP_TICKS  = 8'h0c;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_OUT_DATA   = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_SYNC_EN_BIT = 0;
  localparam int unsigned CTRL_APP_EN_BIT  = 1;
  localparam int unsigned CTRL_MON_EN_BIT  = 2;

  // Sequencer state codes in the status register
  localparam logic [2:0] ST_CODE_STARTUP = 3'h1;
  localparam logic [2:0] ST_CODE_CONFIG  = 3'h2;
  localparam logic [2:0] ST_CODE_GUARDED = 3'h4;
  localparam logic [2:0] ST_CODE_RUN     = 3'h0;
  localparam logic [2:0] ST_CODE_FWLOAD  = 3'h3;

  typedef enum logic [2:0] {
    FSWD_STARTUP,
    FSWD_CONFIG,
    FSWD_GUARDED,
    FSWD_RUN,
    FSWD_FWLOAD
  } fswd_state_t;

endpackage

// ==== verilog/fswd_top.sv ====
// Output watchdog and state sequencer of a fieldbus slave controller
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fswd_top #(
  parameter int unsigned OUT_W = 16
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_N_I,
  // APB slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // Fieldbus side events
  input  wire logic              PD_EXCHANGE_OK_I,
  input  wire logic              PD_OUT_VALID_I,
  input  wire logic [OUT_W-1:0]  PD_OUT_DATA_I,
  input  wire logic              STATE_REQ_I,
  input  wire logic [2:0]        STATE_REQ_CODE_I,
  input  wire logic              MBX_SETUP_OK_I,
  input  wire logic              PD_SETUP_OK_I,
  input  wire logic              INPUTS_COPIED_I,
  // Local application interface activity
  input  wire logic              APP_ACCESS_I,
  // Traffic permission and outputs
  output logic                   MBX_ALLOW_O,
  output logic                   MBX_FILE_ONLY_O,
  output logic                   PD_ALLOW_O,
  output logic                   INPUT_COPY_REQ_O,
  output logic                   STATE_ACK_O,
  output logic                   STATE_ERR_O,
  output logic                   SYNC_WD_EXPIRED_O,
  output logic                   APP_WD_EXPIRED_O,
  output logic [OUT_W-1:0]       OUTPUTS_O
);

  typedef struct packed {
    fswd_pkg::fswd_state_t state;
    logic                  pending;
    logic [15:0]           mult;
    logic [15:0]           sync_ticks;
    logic [15:0]           app_ticks;
    logic                  sync_en;
    logic                  app_en;
    logic                  mon_en;
    logic [3:0]            base_cnt;
    logic [16:0]           tick_cnt;
    logic                  tick;
    logic [15:0]           sync_cnt;
    logic [15:0]           app_cnt;
    logic                  sync_exp;
    logic                  app_exp;
    logic [OUT_W-1:0]      out_data;
    logic                  out_valid;
    logic [OUT_W-1:0]      outputs;
    logic                  mbx_allow;
    logic                  mbx_file;
    logic                  pd_allow;
    logic                  copy_req;
    logic                  ack;
    logic                  err;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } fswd_regs_t;

  fswd_regs_t r_ff;
  fswd_regs_t nxt_r;

  // State code of the sequencer for status readback
  function automatic logic [2:0] state_code(fswd_pkg::fswd_state_t s);
    unique case (s)
      fswd_pkg::FSWD_STARTUP: state_code = fswd_pkg::ST_CODE_STARTUP;
      fswd_pkg::FSWD_CONFIG:  state_code = fswd_pkg::ST_CODE_CONFIG;
      fswd_pkg::FSWD_GUARDED: state_code = fswd_pkg::ST_CODE_GUARDED;
      fswd_pkg::FSWD_RUN:     state_code = fswd_pkg::ST_CODE_RUN;
      default:                state_code = fswd_pkg::ST_CODE_FWLOAD;
    endcase
  endfunction

  logic apb_access;
  logic apb_write;
  logic sync_active;
  logic out_follow;

  assign apb_access = PSEL_I & PENABLE_I & ~r_ff.pready;
  assign apb_write  = apb_access & PWRITE_I;
  // Count zero disables the sync watchdog entirely
  assign sync_active = r_ff.sync_en & (r_ff.sync_ticks != 16'h0000);

  // Next-state logic
  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.ack     = 1'b0;
    nxt_r.err     = 1'b0;
    nxt_r.tick    = 1'b0;
    nxt_r.pready  = 1'b0;
    nxt_r.pslverr = 1'b0;
    nxt_r.prdata  = 32'h0000_0000;
    out_follow    = 1'b0;

    // Tick prescaler: 40 ns base periods, mult+2 of them per tick
    if (r_ff.base_cnt == fswd_pkg::BASE_CNT_LAST)
    begin
      nxt_r.base_cnt = 4'h0;
      if (r_ff.tick_cnt + 17'h00001 >=
          {1'b0, r_ff.mult} + fswd_pkg::TICK_EXTRA_BASES)
      begin
        nxt_r.tick_cnt = 17'h00000;
        nxt_r.tick     = 1'b1;
      end
      else
        nxt_r.tick_cnt = r_ff.tick_cnt + 17'h00001;
    end
    else
      nxt_r.base_cnt = r_ff.base_cnt + 4'h1;

    // Sync-channel watchdog
    if (PD_EXCHANGE_OK_I && r_ff.pd_allow)
    begin
      nxt_r.sync_cnt = 16'h0000;
      nxt_r.sync_exp = 1'b0;
    end
    else if (!sync_active)
    begin
      nxt_r.sync_cnt = 16'h0000;
      nxt_r.sync_exp = 1'b0;
    end
    else if (r_ff.tick && !r_ff.sync_exp)
    begin
      nxt_r.sync_cnt = r_ff.sync_cnt + 16'h0001;
      if (r_ff.sync_cnt + 16'h0001 >= r_ff.sync_ticks)
        nxt_r.sync_exp = 1'b1;
    end

    // Local-interface watchdog
    if (APP_ACCESS_I)
    begin
      nxt_r.app_cnt = 16'h0000;
      nxt_r.app_exp = 1'b0;
    end
    else if (!r_ff.app_en || r_ff.app_ticks == 16'h0000)
    begin
      nxt_r.app_cnt = 16'h0000;
      nxt_r.app_exp = 1'b0;
    end
    else if (r_ff.tick && !r_ff.app_exp)
    begin
      nxt_r.app_cnt = r_ff.app_cnt + 16'h0001;
      if (r_ff.app_cnt + 16'h0001 >= r_ff.app_ticks)
        nxt_r.app_exp = 1'b1;
    end

    // Master output data latch
    if (PD_OUT_VALID_I && r_ff.pd_allow)
    begin
      nxt_r.out_data  = PD_OUT_DATA_I;
      nxt_r.out_valid = 1'b1;
    end

    // Slave state sequencer; watchdog expiry never moves it
    nxt_r.copy_req = 1'b0;
    if (r_ff.pending)
    begin
      // Guarded run entry from config waits for the input copy
      if (INPUTS_COPIED_I)
      begin
        nxt_r.state   = fswd_pkg::FSWD_GUARDED;
        nxt_r.pending = 1'b0;
        nxt_r.ack     = 1'b1;
      end
    end
    else if (STATE_REQ_I)
    begin
      unique case (STATE_REQ_CODE_I)
        fswd_pkg::ST_CODE_STARTUP:
        begin
          nxt_r.state = fswd_pkg::FSWD_STARTUP;
          nxt_r.ack   = 1'b1;
        end
        fswd_pkg::ST_CODE_CONFIG:
          if ((r_ff.state == fswd_pkg::FSWD_STARTUP && MBX_SETUP_OK_I) ||
              r_ff.state == fswd_pkg::FSWD_GUARDED ||
              r_ff.state == fswd_pkg::FSWD_RUN)
          begin
            nxt_r.state = fswd_pkg::FSWD_CONFIG;
            nxt_r.ack   = 1'b1;
          end
          else
            nxt_r.err = 1'b1;
        fswd_pkg::ST_CODE_GUARDED:
          if ((r_ff.state == fswd_pkg::FSWD_CONFIG && PD_SETUP_OK_I) ||
              r_ff.state == fswd_pkg::FSWD_RUN)
          begin
            nxt_r.pending  = r_ff.state == fswd_pkg::FSWD_CONFIG;
            nxt_r.copy_req = r_ff.state == fswd_pkg::FSWD_CONFIG;
            if (r_ff.state == fswd_pkg::FSWD_RUN)
            begin
              nxt_r.state = fswd_pkg::FSWD_GUARDED;
              nxt_r.ack   = 1'b1;
            end
          end
          else
            nxt_r.err = 1'b1;
        fswd_pkg::ST_CODE_RUN:
          if (r_ff.state == fswd_pkg::FSWD_GUARDED && r_ff.out_valid)
          begin
            nxt_r.state = fswd_pkg::FSWD_RUN;
            nxt_r.ack   = 1'b1;
          end
          else
            nxt_r.err = 1'b1;
        fswd_pkg::ST_CODE_FWLOAD:
          if (r_ff.state == fswd_pkg::FSWD_STARTUP)
          begin
            nxt_r.state = fswd_pkg::FSWD_FWLOAD;
            nxt_r.ack   = 1'b1;
          end
          else
            nxt_r.err = 1'b1;
        default:
          nxt_r.err = 1'b1;
      endcase
    end

    // Output data is stale once we drop below guarded run
    if (nxt_r.state == fswd_pkg::FSWD_STARTUP ||
        nxt_r.state == fswd_pkg::FSWD_CONFIG)
      nxt_r.out_valid = 1'b0;

    // Traffic permission per state
    unique case (nxt_r.state)
      fswd_pkg::FSWD_STARTUP:
      begin
        nxt_r.mbx_allow = 1'b0;
        nxt_r.mbx_file  = 1'b0;
        nxt_r.pd_allow  = 1'b0;
      end
      fswd_pkg::FSWD_CONFIG:
      begin
        nxt_r.mbx_allow = 1'b1;
        nxt_r.mbx_file  = 1'b0;
        nxt_r.pd_allow  = 1'b0;
      end
      fswd_pkg::FSWD_FWLOAD:
      begin
        nxt_r.mbx_allow = 1'b1;
        nxt_r.mbx_file  = 1'b1;
        nxt_r.pd_allow  = 1'b0;
      end
      default:
      begin
        nxt_r.mbx_allow = 1'b1;
        nxt_r.mbx_file  = 1'b0;
        nxt_r.pd_allow  = 1'b1;
      end
    endcase

    // Outputs follow master data in run, or guarded run when unmonitored
    if (r_ff.state == fswd_pkg::FSWD_RUN)
      out_follow = 1'b1;
    else if (r_ff.state == fswd_pkg::FSWD_GUARDED && !r_ff.mon_en)
      out_follow = 1'b1;
    if (out_follow && !(r_ff.sync_exp && sync_active) && r_ff.out_valid)
      nxt_r.outputs = r_ff.out_data;
    else
      nxt_r.outputs = fswd_pkg::RST_OUT_VALUE;

    // APB register access, one wait state
    if (apb_access)
    begin
      nxt_r.pready = 1'b1;
      unique case (PADDR_I)
        fswd_pkg::OFS_CTRL:
          if (apb_write)
          begin
            nxt_r.sync_en = PWDATA_I[fswd_pkg::CTRL_SYNC_EN_BIT];
            nxt_r.app_en  = PWDATA_I[fswd_pkg::CTRL_APP_EN_BIT];
            nxt_r.mon_en  = PWDATA_I[fswd_pkg::CTRL_MON_EN_BIT];
          end
          else
            nxt_r.prdata = {29'h0, r_ff.mon_en, r_ff.app_en, r_ff.sync_en};
        fswd_pkg::OFS_MULT:
          if (apb_write)
          begin
            // Zero multiplier is outside the range and refused
            if (PWDATA_I[15:0] != 16'h0000)
              nxt_r.mult = PWDATA_I[15:0];
            else
              nxt_r.pslverr = 1'b1;
          end
          else
            nxt_r.prdata = {16'h0, r_ff.mult};
        fswd_pkg::OFS_SYNC_TICKS:
          if (apb_write)
            nxt_r.sync_ticks = PWDATA_I[15:0];
          else
            nxt_r.prdata = {16'h0, r_ff.sync_ticks};
        fswd_pkg::OFS_APP_TICKS:
          if (apb_write)
            nxt_r.app_ticks = PWDATA_I[15:0];
          else
            nxt_r.prdata = {16'h0, r_ff.app_ticks};
        fswd_pkg::OFS_STATUS:
          if (!apb_write)
            nxt_r.prdata = {27'h0, r_ff.app_exp, r_ff.sync_exp,
                            state_code(r_ff.state)};
        fswd_pkg::OFS_OUT_DATA:
          if (!apb_write)
            nxt_r.prdata = 32'(r_ff.outputs);
        default:
          nxt_r.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      r_ff            <= '0;
      r_ff.state      <= fswd_pkg::FSWD_STARTUP;
      r_ff.mult       <= fswd_pkg::RST_MULT;
      r_ff.sync_ticks <= fswd_pkg::RST_SYNC_TICKS;
      r_ff.app_ticks  <= fswd_pkg::RST_APP_TICKS;
      r_ff.sync_en    <= 1'b1;
      r_ff.app_en     <= 1'b1;
      r_ff.mon_en     <= 1'b1;
    end
    else
      r_ff <= nxt_r;
  end

  assign PRDATA_O          = r_ff.prdata;
  assign PREADY_O          = r_ff.pready;
  assign PSLVERR_O         = r_ff.pslverr;
  assign MBX_ALLOW_O       = r_ff.mbx_allow;
  assign MBX_FILE_ONLY_O   = r_ff.mbx_file;
  assign PD_ALLOW_O        = r_ff.pd_allow;
  assign INPUT_COPY_REQ_O  = r_ff.copy_req;
  assign STATE_ACK_O       = r_ff.ack;
  assign STATE_ERR_O       = r_ff.err;
  assign SYNC_WD_EXPIRED_O = r_ff.sync_exp;
  assign APP_WD_EXPIRED_O  = r_ff.app_exp;
  assign OUTPUTS_O         = r_ff.outputs;

endmodule

// ==== bench/fswd_checker.sv ====
// Concurrent checks on the output watchdog block ports
`timescale 1ns/1ps
module fswd_checker #(
  parameter int unsigned OUT_W = 16
) (
  input wire logic             CLK_SYS_I,
  input wire logic             RESET_N_I,
  input wire logic             PSEL_I,
  input wire logic             PENABLE_I,
  input wire logic [31:0]      PRDATA_O,
  input wire logic             PREADY_O,
  input wire logic             PD_EXCHANGE_OK_I,
  input wire logic             STATE_REQ_I,
  input wire logic [2:0]       STATE_REQ_CODE_I,
  input wire logic             INPUTS_COPIED_I,
  input wire logic             APP_ACCESS_I,
  input wire logic             MBX_ALLOW_O,
  input wire logic             PD_ALLOW_O,
  input wire logic             INPUT_COPY_REQ_O,
  input wire logic             STATE_ACK_O,
  input wire logic             STATE_ERR_O,
  input wire logic             SYNC_WD_EXPIRED_O,
  input wire logic             APP_WD_EXPIRED_O,
  input wire logic [OUT_W-1:0] OUTPUTS_O
);
  // Guarded-run entry in progress, from the copy request to its ack
  logic pend_q;
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      pend_q <= 1'b0;
    else if (INPUT_COPY_REQ_O)
      pend_q <= 1'b1;
    else if (STATE_ACK_O)
      pend_q <= 1'b0;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // Bus access taken, then a one-cycle answer
  sequence s_taken; PSEL_I && PENABLE_I && !PREADY_O; endsequence
  sequence s_answer; PREADY_O ##1 !PREADY_O; endsequence
  a_apb_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not a single cycle after access");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data not zero outside answer");
  a_reset_startup: assert property ($rose(RESET_N_I) |->
    !MBX_ALLOW_O && !PD_ALLOW_O) else $error("traffic allowed after reset");
  a_fwload_refused: assert property (STATE_REQ_I && MBX_ALLOW_O &&
    !INPUT_COPY_REQ_O && !pend_q &&
    STATE_REQ_CODE_I == fswd_pkg::ST_CODE_FWLOAD |=> STATE_ERR_O)
    else $error("firmware load request not refused");
  a_outputs_forced: assert property (SYNC_WD_EXPIRED_O &&
    $past(SYNC_WD_EXPIRED_O) |-> OUTPUTS_O == '0)
    else $error("outputs driven while sync watchdog expired");
  a_sync_restart: assert property (PD_EXCHANGE_OK_I && PD_ALLOW_O
    |=> !SYNC_WD_EXPIRED_O) else $error("sync watchdog not restarted");
  a_app_restart: assert property (APP_ACCESS_I |=> !APP_WD_EXPIRED_O)
    else $error("local watchdog not restarted");
  a_ack_after_copy: assert property (STATE_ACK_O &&
    (pend_q || INPUT_COPY_REQ_O) |-> $past(INPUTS_COPIED_I))
    else $error("ack before input copy");
endmodule

// ==== bench/fswd_master_model.sv ====
// Fieldbus master model: state requests and process data exchanges
`timescale 1ns/1ps
module fswd_master_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic        copy_req_i,
  output logic             req_o,
  output logic [2:0]       code_o,
  output logic             mbx_ok_o,
  output logic             pd_ok_o,
  output logic             copied_o,
  output logic             xchg_o,
  output logic             valid_o,
  output logic [15:0]      data_o
);
  // Channel setup reported complete until a test says otherwise
  initial
  begin
    req_o = 1'h0;
    code_o = 3'h7;
    mbx_ok_o = 1'h1;
    pd_ok_o = 1'h1;
    copied_o = 1'h0;
    xchg_o = 1'h0;
    valid_o = 1'h0;
    data_o = 16'hffff;
  end
  // Set the outcome of the mailbox and process data setup checks
  task automatic setup(input logic m, input logic p);
    @(posedge clk_i);
    mbx_ok_o <= m;
    pd_ok_o <= p;
  endtask
  // Request a state, copy inputs when asked, return 1 ack, 0 err, 2 none
  task automatic req(input logic [2:0] c, output int r);
    int n;
    begin
      r = 2;
      @(posedge clk_i);
      req_o <= 1'h1;
      code_o <= c;
      @(posedge clk_i);
      req_o <= 1'h0;
      code_o <= ~c;
      for (n = 0; n < 60 && r == 2; n++)
      begin
        if (copy_req_i === 1'h1)
        begin
          repeat (3) @(posedge clk_i);
          copied_o <= 1'h1;
          @(posedge clk_i);
          copied_o <= 1'h0;
        end
        if (ack_i === 1'h1) r = 1;
        else if (err_i === 1'h1) r = 0;
        if (r == 2) @(posedge clk_i);
      end
    end
  endtask
  // One good exchange carrying output data; data line garbled after
  task automatic pd(input logic [15:0] d);
    @(posedge clk_i);
    xchg_o <= 1'h1;
    valid_o <= 1'h1;
    data_o <= d;
    @(posedge clk_i);
    xchg_o <= 1'h0;
    valid_o <= 1'h0;
    data_o <= ~d;
  endtask
endmodule

// ==== bench/fswd_top_tb.sv ====
// Testbench for the output watchdog and state sequencer
`timescale 1ns/1ps
module fswd_top_tb;
  logic CLK_SYS_I = 1'h0, RESET_N_I = 1'h0, PSEL_I = 1'h0;
  logic PENABLE_I = 1'h0, PWRITE_I = 1'h0, APP_ACCESS_I = 1'h0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdv;
  logic PREADY_O, PSLVERR_O, erv, PD_EXCHANGE_OK_I, PD_OUT_VALID_I;
  logic STATE_REQ_I, MBX_SETUP_OK_I, PD_SETUP_OK_I, INPUTS_COPIED_I;
  logic MBX_ALLOW_O, MBX_FILE_ONLY_O, PD_ALLOW_O, INPUT_COPY_REQ_O;
  logic STATE_ACK_O, STATE_ERR_O, SYNC_WD_EXPIRED_O, APP_WD_EXPIRED_O;
  logic [2:0] STATE_REQ_CODE_I;
  logic [15:0] PD_OUT_DATA_I, OUTPUTS_O;
  int fails = 0, comparisons = 0, r, n;
  always #2 CLK_SYS_I = ~CLK_SYS_I;
  fswd_top DUT (.*);
  fswd_master_model u_master (.clk_i(CLK_SYS_I), .ack_i(STATE_ACK_O),
    .err_i(STATE_ERR_O), .copy_req_i(INPUT_COPY_REQ_O),
    .req_o(STATE_REQ_I), .code_o(STATE_REQ_CODE_I),
    .mbx_ok_o(MBX_SETUP_OK_I), .pd_ok_o(PD_SETUP_OK_I),
    .copied_o(INPUTS_COPIED_I), .xchg_o(PD_EXCHANGE_OK_I),
    .valid_o(PD_OUT_VALID_I), .data_o(PD_OUT_DATA_I));
  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One bus transfer; holds the request until the answer edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    begin
      @(posedge CLK_SYS_I);
      PSEL_I <= 1'h1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_SYS_I);
      PENABLE_I <= 1'h1;
      k = 0;
      do
      begin
        @(posedge CLK_SYS_I);
        k++;
      end
      while (PREADY_O !== 1'h1 && k < 20);
      rdv = PRDATA_O;
      erv = PSLVERR_O;
      PSEL_I <= 1'h0;
      PENABLE_I <= 1'h0;
      if (k >= 20) chk(32'h0, 32'h1);
      if (k >= 20) give_verdict();
    end
  endtask
  initial
  begin
    repeat (12) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'h1;
    apb(1'h0, fswd_pkg::OFS_MULT, 32'h0);
    chk(rdv, 32'h000009c2);
    apb(1'h0, fswd_pkg::OFS_SYNC_TICKS, 32'h0);
    chk(rdv, 32'h000003e8);
    apb(1'h0, fswd_pkg::OFS_APP_TICKS, 32'h0);
    chk(rdv, 32'h000003e8);
    apb(1'h0, fswd_pkg::OFS_STATUS, 32'h0);
    chk(rdv, 32'h00000001);
    apb(1'h0, 8'h18, 32'h0);
    chk({31'h0, erv}, 32'h1);
    apb(1'h1, fswd_pkg::OFS_MULT, 32'h0);
    chk({31'h0, erv}, 32'h1);
    apb(1'h1, fswd_pkg::OFS_MULT, 32'h0000ffff);
    apb(1'h0, fswd_pkg::OFS_MULT, 32'h0);
    chk(rdv, 32'h0000ffff);
    apb(1'h1, fswd_pkg::OFS_MULT, 32'h00000001);
    apb(1'h1, fswd_pkg::OFS_SYNC_TICKS, 32'h00000002);
    apb(1'h1, fswd_pkg::OFS_APP_TICKS, 32'h00000002);
    $display("test registers done");
    u_master.setup(1'h0, 1'h0);
    u_master.req(fswd_pkg::ST_CODE_CONFIG, r);
    chk(r, 0);
    u_master.req(fswd_pkg::ST_CODE_FWLOAD, r);
    chk(r, 1);
    chk({30'h0, MBX_FILE_ONLY_O, PD_ALLOW_O}, 32'h2);
    u_master.req(fswd_pkg::ST_CODE_STARTUP, r);
    chk(r, 1);
    u_master.setup(1'h1, 1'h0);
    u_master.req(fswd_pkg::ST_CODE_CONFIG, r);
    chk(r, 1);
    chk({30'h0, MBX_ALLOW_O, PD_ALLOW_O}, 32'h2);
    u_master.req(fswd_pkg::ST_CODE_FWLOAD, r);
    chk(r, 0);
    u_master.req(fswd_pkg::ST_CODE_GUARDED, r);
    chk(r, 0);
    u_master.setup(1'h1, 1'h1);
    u_master.req(fswd_pkg::ST_CODE_GUARDED, r);
    chk(r, 1);
    u_master.req(fswd_pkg::ST_CODE_RUN, r);
    chk(r, 0);
    u_master.pd(16'ha5c3);
    repeat (2) @(posedge CLK_SYS_I);
    chk({PD_ALLOW_O, OUTPUTS_O}, 32'h00010000);
    u_master.req(fswd_pkg::ST_CODE_RUN, r);
    repeat (2) @(posedge CLK_SYS_I);
    chk({r[15:0], OUTPUTS_O}, 32'h0001a5c3);
    $display("test states done");
    u_master.pd(16'ha5c3);
    for (n = 0; n < 200 && SYNC_WD_EXPIRED_O !== 1'h1; n++)
      @(posedge CLK_SYS_I);
    chk(n >= 30 && n <= 62, 1);
    repeat (2) @(posedge CLK_SYS_I);
    chk({APP_WD_EXPIRED_O, OUTPUTS_O}, 32'h00010000);
    apb(1'h0, fswd_pkg::OFS_STATUS, 32'h0);
    chk(rdv & 32'h0000000f, 32'h00000008);
    @(posedge CLK_SYS_I);
    APP_ACCESS_I <= 1'h1;
    @(posedge CLK_SYS_I);
    APP_ACCESS_I <= 1'h0;
    @(posedge CLK_SYS_I);
    chk(APP_WD_EXPIRED_O, 1'h0);
    u_master.pd(16'h5a3c);
    repeat (2) @(posedge CLK_SYS_I);
    chk({SYNC_WD_EXPIRED_O, OUTPUTS_O}, 32'h00005a3c);
    apb(1'h1, fswd_pkg::OFS_SYNC_TICKS, 32'h0);
    u_master.pd(16'h5a3c);
    repeat (150) @(posedge CLK_SYS_I);
    chk({SYNC_WD_EXPIRED_O, OUTPUTS_O}, 32'h00005a3c);
    $display("test watchdogs done");
    apb(1'h1, fswd_pkg::OFS_CTRL, 32'h00000003);
    apb(1'h0, fswd_pkg::OFS_CTRL, 32'h0);
    chk(rdv, 32'h00000003);
    u_master.req(fswd_pkg::ST_CODE_GUARDED, r);
    chk(r, 1);
    u_master.pd(16'h1234);
    repeat (2) @(posedge CLK_SYS_I);
    chk({PD_ALLOW_O, OUTPUTS_O}, 32'h00011234);
    apb(1'h0, fswd_pkg::OFS_OUT_DATA, 32'h0);
    chk(rdv, 32'h00001234);
    apb(1'h0, fswd_pkg::OFS_STATUS, 32'h0);
    chk(rdv & 32'h0000000f, 32'h00000004);
    $display("test monitor done");
    give_verdict();
  end
endmodule
bind fswd_top fswd_checker #(.OUT_W(OUT_W)) u_chk (.CLK_SYS_I, .RESET_N_I,
  .PSEL_I, .PENABLE_I, .PRDATA_O, .PREADY_O, .PD_EXCHANGE_OK_I,
  .STATE_REQ_I, .STATE_REQ_CODE_I, .INPUTS_COPIED_I, .APP_ACCESS_I,
  .MBX_ALLOW_O, .PD_ALLOW_O, .INPUT_COPY_REQ_O, .STATE_ACK_O,
  .STATE_ERR_O, .SYNC_WD_EXPIRED_O, .APP_WD_EXPIRED_O, .OUTPUTS_O);
